/* File: dv/cihp_calc_model.sv */
`timescale 1ns/1ps
module cihp_calc_model
	import cihp_pkg::*;
(
	input wire logic clock,
	input wire logic [DATA_W-1:0] host_data_line_out,
	input wire logic [DATA_W-1:0] host_data_line_oe,
	input wire logic host_ready_flag,
	output logic [SEL_W-1:0] periph_addr_bit,
	output logic xfer_dir_out,
	output logic reg_code_hi,
	output logic reg_code_lo,
	output logic io_strobe,
	output logic poll_demand_n,
	output logic host_init_n,
	output logic [DATA_W-1:0] host_data_line_in
);
	logic drv;
	logic [DATA_W-1:0] dat;

	// wire level: port first, then calculator, else pull-up
	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			host_data_line_in[i] = host_data_line_oe[i] ? host_data_line_out[i] : (drv ? dat[i] : 1'b1);
		end
	end

	// idle slot, nothing selected
	initial begin
		periph_addr_bit = 4'h0;
		xfer_dir_out = 1'b0;
		{reg_code_hi, reg_code_lo} = 2'h0;
		io_strobe = 1'b0;
		poll_demand_n = 1'b1;
		host_init_n = 1'b1;
		drv = 1'b0;
		dat = 8'h00;
	end

	////////////////////////////////////////////////////////////
	// lines settle first
	task automatic lines(input logic [3:0] a, input logic d, input logic [1:0] c);
		@(posedge clock);
		periph_addr_bit <= a;
		xfer_dir_out <= d;
		{reg_code_hi, reg_code_lo} <= c;
		repeat (6) @(posedge clock);
	endtask

	task automatic request(input logic [3:0] a, input logic d, input logic [1:0] c, input logic [7:0] v,
		output logic seen);
		dat <= v;
		drv <= d;
		lines(a, d, c);
		io_strobe <= 1'b1;
		seen = 1'b0;
		for (int n = 0; n < 12 && !seen; n++) begin
			@(posedge clock);
			seen = (host_ready_flag === 1'b1);
		end
		io_strobe <= 1'b0;
		repeat (5) @(posedge clock);
		// release the data lines once the strobe is long gone
		drv <= 1'b0;
	endtask

	task automatic poll(input logic on);
		@(posedge clock);
		poll_demand_n <= !on;
		repeat (8) @(posedge clock);
	endtask

	// initialize held low long enough to pass the pin filter
	task automatic init_pulse();
		@(posedge clock);
		host_init_n <= 1'b0;
		repeat (8) @(posedge clock);
		host_init_n <= 1'b1;
		repeat (6) @(posedge clock);
	endtask
endmodule

/* File: dv/cihp_port_test.sv */
`timescale 1ns/1ps
module cihp_port_test
	import cihp_pkg::*;
;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [SEL_W-1:0] sel_code = 4'h9;
	logic iface_error = 1'b0;
	logic [INSTR_W-1:0] instr_addr = 3'h0;
	logic [DATA_W-1:0] instr_wr_data = 8'h00;
	logic instr_wr_stb = 1'b0;
	logic instr_rd_stb = 1'b0;
	wire logic [SEL_W-1:0] pa;
	wire logic init_n, poll_n, stb, dir, chi, clo, flag, stat, irql_n, irqh_n, pend, osc;
	wire logic [DATA_W-1:0] din, dout, doe, rdat;
	int err_total = 0;
	int n_tests = 0;
	logic seen;
	logic [7:0] v;

	always #2.5 clock = ~clock;

	cihp_port u_dut (.clock(clock), .reset(reset), .sel_code(sel_code), .host_init_n(init_n),
		.poll_demand_n(poll_n), .io_strobe(stb), .xfer_dir_out(dir), .reg_code_hi(chi), .reg_code_lo(clo),
		.periph_addr_bit(pa), .host_data_line_in(din), .host_data_line_out(dout), .host_data_line_oe(doe),
		.host_ready_flag(flag), .host_present_status(stat), .irq_low_group_n(irql_n),
		.irq_high_group_n(irqh_n), .iface_error(iface_error), .instr_addr(instr_addr),
		.instr_wr_data(instr_wr_data), .instr_wr_stb(instr_wr_stb), .instr_rd_stb(instr_rd_stb),
		.instr_rd_data(rdat), .request_pending_flag(pend), .ctl_osc(osc));

	cihp_calc_model u_calc (.clock(clock), .host_data_line_out(dout), .host_data_line_oe(doe),
		.host_ready_flag(flag), .periph_addr_bit(pa), .xfer_dir_out(dir), .reg_code_hi(chi),
		.reg_code_lo(clo), .io_strobe(stb), .poll_demand_n(poll_n), .host_init_n(init_n),
		.host_data_line_in(din));

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		instr_addr <= a;
		instr_wr_data <= d;
		instr_wr_stb <= 1'b1;
		@(posedge clock);
		instr_wr_stb <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	// read data stands only in the cycle after the read edge
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		instr_addr <= a;
		instr_rd_stb <= 1'b1;
		@(posedge clock);
		instr_rd_stb <= 1'b0;
		#1 d = instr_rd_data_w();
	endtask

	function automatic logic [7:0] instr_rd_data_w();
		return rdat;
	endfunction

	task automatic set_sel(input logic [3:0] s);
		@(posedge clock);
		sel_code <= s;
		repeat (6) @(posedge clock);
	endtask

	////////////////////////////////////////////////////////////
	// every register code, output direction, then cleared
	task automatic t_output();
		for (int c = 0; c < 4; c++) begin
			u_calc.request(4'h9, 1'b1, c[1:0], 8'h5a ^ c[7:0], seen);
			chk(8'h01, {7'h0, seen});
			chk(8'h01, {7'h0, pend});
			rd(INSTR_READ_CMD, v);
			chk((8'h10 << c) | 8'h0c | c[7:0], v);
			rd(INSTR_READ_OUT, v);
			chk(8'h5a ^ c[7:0], v);
			wr(INSTR_CLEAR_CMD, 8'h00);
			chk(8'h00, {6'h0, flag, pend});
		end
		$display("output test done");
	endtask

	// request to another address is ignored
	task automatic t_miss();
		u_calc.request(4'h3, 1'b1, 2'h3, 8'h11, seen);
		chk(8'h00, {6'h0, seen, pend});
		$display("address test done");
	endtask

	// input data to calculator, then poll takes the lines over
	task automatic t_input();
		wr(INSTR_LOAD_IN, 8'hc3);
		u_calc.request(4'h9, 1'b0, 2'h0, 8'h00, seen);
		rd(INSTR_READ_CMD, v);
		chk(8'h18, v);
		chk(8'hc3, din);
		chk(8'hff, doe);
		rd(INSTR_READ_STATUS, v);
		chk(8'h09, v);
		wr(INSTR_CLEAR_CMD, 8'h00);
		u_calc.poll(1'b1);
		chk(8'h02, doe);
		chk(8'hfd, din);
		u_calc.lines(4'h1, 1'b0, 2'h0);
		chk(8'h00, doe);
		u_calc.poll(1'b0);
		$display("input test done");
	endtask

	// request line by group, withheld during a poll
	task automatic t_irq();
		u_calc.lines(4'h9, 1'b1, 2'h0);
		wr(INSTR_RAISE_IRQ, 8'h01);
		chk(8'h02, {6'h0, irql_n, irqh_n});
		u_calc.poll(1'b1);
		chk(8'h03, {6'h0, irql_n, irqh_n});
		u_calc.poll(1'b0);
		wr(INSTR_RAISE_IRQ, 8'h00);
		set_sel(4'h5);
		wr(INSTR_RAISE_IRQ, 8'h01);
		chk(8'h01, {6'h0, irql_n, irqh_n});
		wr(INSTR_RAISE_IRQ, 8'h00);
		chk(8'h03, {6'h0, irql_n, irqh_n});
		$display("interrupt test done");
	endtask

	// status line, unmapped read, oscillator shape
	task automatic t_misc();
		iface_error <= 1'b1;
		repeat (3) @(posedge clock);
		chk(8'h01, {7'h0, stat});
		iface_error <= 1'b0;
		repeat (3) @(posedge clock);
		chk(8'h00, {7'h0, stat});
		wr(INSTR_RAISE_IRQ, 8'h01);
		u_calc.request(4'h5, 1'b1, 2'h0, 8'h77, seen);
		chk(8'h0d, {4'h0, flag, pend, irql_n, irqh_n});
		u_calc.init_pulse();
		chk(8'h03, {4'h0, flag, pend, irql_n, irqh_n});
		rd(3'h7, v);
		chk(8'h00, v);
		for (int n = 0; n < 200 && !(osc === 1'b1); n++) @(posedge clock);
		v = 8'h00;
		for (int n = 0; n < 100; n++) begin
			@(posedge clock);
			v = v + {7'h0, osc === 1'b1};
		end
		chk(8'd33, v);
		$display("misc test done");
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		print_verdict();
	end

	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		repeat (5) @(posedge clock);
		chk(8'h03, {4'h0, flag, pend, irql_n, irqh_n});
		t_output();
		t_miss();
		t_input();
		t_irq();
		t_misc();
		print_verdict();
	end
endmodule

/* File: hdl/cihp_port.sv */
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
// Operation
// - respond only when address matches select code
// - flag low when ready, status low without error
// - direction line high means output request
// - output request latches calculator data byte
// - input request drives input latch unless polling
// - strobe latches direction and register code
// - every request sets the pending bit
// - pending bit holds flag high, busy
// - read command puts latched code on bus
// - clear command resets latch and pending bit
// - read output data puts byte on bus
// - load input data captures processor byte
// - raise interrupt pulls line low unless polling
// - low group for 0-7, high for 8-15
// - poll with matching top bit pulls indexed line
// - processor watches pending flag, executes operation
// - processor commands through instruction lines, byte bus
// - asymmetric 2 MHz oscillator drives control logic
// - register code decodes to R7, R6, R5, R4
module cihp_port
	import cihp_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic [SEL_W-1:0] sel_code,
	input wire logic host_init_n,
	input wire logic poll_demand_n,
	input wire logic io_strobe,
	input wire logic xfer_dir_out,
	input wire logic reg_code_hi,
	input wire logic reg_code_lo,
	input wire logic [SEL_W-1:0] periph_addr_bit,
	input wire logic [DATA_W-1:0] host_data_line_in,
	output logic [DATA_W-1:0] host_data_line_out,
	output logic [DATA_W-1:0] host_data_line_oe,
	output logic host_ready_flag,
	output logic host_present_status,
	output logic irq_low_group_n,
	output logic irq_high_group_n,
	input wire logic iface_error,
	input wire logic [INSTR_W-1:0] instr_addr,
	input wire logic [DATA_W-1:0] instr_wr_data,
	input wire logic instr_wr_stb,
	input wire logic instr_rd_stb,
	output logic [DATA_W-1:0] instr_rd_data,
	output logic request_pending_flag,
	output logic ctl_osc
);

	// register code to one-hot {R4,R5,R6,R7}, used by the command read only
	function automatic logic [3:0] reg_onehot(input logic hi, input logic lo);
		logic [3:0] sel;
		sel = 4'h0;
		case ({hi, lo})
			REG_CODE_R7: sel = 4'h1;
			REG_CODE_R6: sel = 4'h2;
			REG_CODE_R5: sel = 4'h4;
			REG_CODE_R4: sel = 4'h8;
			default: sel = 4'h0;
		endcase
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser: three stages, value accepted once stages two and three agree

	logic [PINS_W-1:0] s1_q, s1_d;
	logic [PINS_W-1:0] s2_q, s2_d;
	logic [PINS_W-1:0] s3_q, s3_d;
	logic [PINS_W-1:0] stable_q, stable_d;
	logic strobe_prev_q, strobe_prev_d;
	cihp_pins_t pin;

	// raw pins gathered; stage one feeds stage two only
	always_comb begin
		s1_d = {sel_code, host_init_n, poll_demand_n, io_strobe, xfer_dir_out,
			reg_code_hi, reg_code_lo, periph_addr_bit, host_data_line_in};
		s2_d = s1_q;
		s3_d = s2_q;
		strobe_prev_d = pin.strobe;
	end

	// per-bit agreement filter so a one-sample glitch never lands
	for (genvar i = 0; i < PINS_W; i++) begin : g_agree
		assign stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
	end

	// idle levels: strobe low, active-low lines high
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s1_q <= PINS_RESET;
			s2_q <= PINS_RESET;
			s3_q <= PINS_RESET;
			stable_q <= PINS_RESET;
			strobe_prev_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			stable_q <= stable_d;
			strobe_prev_q <= strobe_prev_d;
		end
	end

	assign pin = cihp_pins_t'(stable_q);

	////////////////////////////////////////////////////////////////////////////
	// request decode

	logic selected;
	logic strobe_edge;
	logic take;
	logic polling;
	logic init_act;

	assign selected = (pin.addr == pin.sel_code);
	assign strobe_edge = pin.strobe & ~strobe_prev_q;
	assign take = strobe_edge & selected;
	// poll is the calculator's low level, only observed here
	assign polling = ~pin.poll_n;
	assign init_act = ~pin.init_n;

	////////////////////////////////////////////////////////////////////////////
	// command latch, data latches and interrupt request

	cihp_cmd_t cmd_q, cmd_d;
	logic [DATA_W-1:0] outb_q, outb_d;
	logic [DATA_W-1:0] inb_q, inb_d;
	logic irq_req_q, irq_req_d;
	logic wr_clear, wr_load, wr_irq;

	assign wr_clear = instr_wr_stb & (instr_addr == INSTR_CLEAR_CMD);
	assign wr_load = instr_wr_stb & (instr_addr == INSTR_LOAD_IN);
	assign wr_irq = instr_wr_stb & (instr_addr == INSTR_RAISE_IRQ);

	// a request in the clear cycle wins over the clear; only an initialize drops it
	always_comb begin
		cmd_d = cmd_q;
		outb_d = outb_q;
		inb_d = inb_q;
		irq_req_d = irq_req_q;
		if (wr_clear) begin
			cmd_d = CMD_RESET;
		end
		if (take) begin
			cmd_d = '{pend: 1'b1, dir_out: pin.dir_out, code_hi: pin.code_hi, code_lo: pin.code_lo};
		end
		if (take && pin.dir_out) begin
			outb_d = pin.data;
		end
		if (wr_load) begin
			inb_d = instr_wr_data;
		end
		// interrupt request level, bit zero sets or drops it
		if (wr_irq) begin
			irq_req_d = instr_wr_data[0];
		end
		// calculator initialize clears the command latch and interrupt request, not the data latches
		if (init_act) begin
			cmd_d = CMD_RESET;
			irq_req_d = IRQ_REQ_RESET;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cmd_q <= CMD_RESET;
			outb_q <= BYTE_RESET;
			inb_q <= BYTE_RESET;
			irq_req_q <= IRQ_REQ_RESET;
		end else begin
			cmd_q <= cmd_d;
			outb_q <= outb_d;
			inb_q <= inb_d;
			irq_req_q <= irq_req_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// calculator-side outputs, all registered

	logic [DATA_W-1:0] dout_d, doe_d;
	logic flag_d, status_d, irql_d, irqh_d, pendo_d;
	logic drive_in;
	logic poll_match;

	// input request drive, suppressed in a poll
	assign drive_in = selected & ~pin.dir_out & ~polling;
	// poll answered by group top bit
	assign poll_match = polling & (pin.addr[SEL_W-1] == pin.sel_code[SEL_W-1]);

	// open-drain poll answer: only the indexed line is enabled, at low level
	for (genvar b = 0; b < DATA_W; b++) begin : g_line
		always_comb begin
			if (poll_match) begin
				dout_d[b] = 1'b0;
				doe_d[b] = (pin.sel_code[LINE_IDX_W-1:0] == LINE_IDX_W'(b));
			end else begin
				dout_d[b] = inb_q[b];
				doe_d[b] = drive_in;
			end
		end
	end

	always_comb begin
		flag_d = cmd_d.pend;
		status_d = iface_error;
		pendo_d = cmd_d.pend;
		// group chosen by switch top bit
		irql_d = ~(irq_req_d & ~polling & ~pin.sel_code[SEL_W-1]);
		irqh_d = ~(irq_req_d & ~polling & pin.sel_code[SEL_W-1]);
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			host_data_line_out <= '0;
			host_data_line_oe <= '0;
			host_ready_flag <= 1'b0;
			host_present_status <= 1'b0;
			request_pending_flag <= 1'b0;
			irq_low_group_n <= 1'b1;
			irq_high_group_n <= 1'b1;
		end else begin
			host_data_line_out <= dout_d;
			host_data_line_oe <= doe_d;
			host_ready_flag <= flag_d;
			host_present_status <= status_d;
			request_pending_flag <= pendo_d;
			irq_low_group_n <= irql_d;
			irq_high_group_n <= irqh_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// processor read path: answer in the cycle after the strobe, zero otherwise

	logic [DATA_W-1:0] rd_d;

	always_comb begin
		rd_d = '0;
		if (instr_rd_stb) begin
			case (instr_addr)
				INSTR_READ_CMD: rd_d = {reg_onehot(cmd_q.code_hi, cmd_q.code_lo), cmd_q};
				INSTR_READ_OUT: rd_d = outb_q;
				INSTR_READ_STATUS: begin
					rd_d[STAT_SELECTED_BIT] = selected;
					rd_d[STAT_POLL_BIT] = polling;
					rd_d[STAT_IRQ_REQ_BIT] = irq_req_q;
					rd_d[STAT_PENDING_BIT] = cmd_q.pend;
				end
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			instr_rd_data <= '0;
		end else begin
			instr_rd_data <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control oscillator, asymmetric; kept free-running so its phase is predictable

	localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(OSC_PERIOD_CYC - 1);
	localparam logic [OSC_CNT_W-1:0] OSC_HIGH = OSC_CNT_W'(OSC_HIGH_CYC);
	logic [OSC_CNT_W-1:0] osc_cnt_q, osc_cnt_d;
	logic osc_d;

	always_comb begin
		osc_cnt_d = (osc_cnt_q == OSC_LAST) ? '0 : osc_cnt_q + 1'b1;
		osc_d = (osc_cnt_d < OSC_HIGH);
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			// start at the period end so the first high phase is full length
			osc_cnt_q <= OSC_LAST;
			ctl_osc <= 1'b0;
		end else begin
			osc_cnt_q <= osc_cnt_d;
			ctl_osc <= osc_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sel_gate_a: assert property ($rose(cmd_q.pend) |-> $past(selected) || $past(init_act))
		else $error("pending set without address match");

	status_line_a: assert property (##1 host_present_status == $past(iface_error))
		else $error("status line does not follow error");

	out_capture_a: assert property (take && pin.dir_out && !init_act |=> outb_q == $past(pin.data))
		else $error("output byte not captured");

	in_drive_a: assert property (drive_in && !poll_match |=> host_data_line_oe == 8'hff && host_data_line_out == $past(inb_q))
		else $error("input byte not driven");

	cmd_capture_a: assert property (take && !init_act |=> cmd_q == {1'b1, $past(pin.dir_out), $past(pin.code_hi), $past(pin.code_lo)})
		else $error("command latch wrong");

	flag_busy_a: assert property (take && !init_act |=> host_ready_flag && request_pending_flag)
		else $error("flag not busy after request");

	clear_cmd_a: assert property (wr_clear && !take |=> !cmd_q.pend ##0 !host_ready_flag)
		else $error("clear did not ready the port");

	read_out_a: assert property (instr_rd_stb && instr_addr == INSTR_READ_OUT |=> instr_rd_data == $past(outb_q))
		else $error("read output byte wrong");

	load_in_a: assert property (wr_load |=> inb_q == $past(instr_wr_data))
		else $error("input latch not loaded");

	irq_poll_a: assert property (polling |=> irq_low_group_n && irq_high_group_n)
		else $error("interrupt line low during poll");

	poll_resp_a: assert property (poll_match |=> host_data_line_oe == (8'h01 << $past(pin.sel_code[2:0])) && host_data_line_out == 8'h00)
		else $error("poll answer on wrong line");

	osc_high_a: assert property ($rose(ctl_osc) |-> ##32 ctl_osc ##1 !ctl_osc)
		else $error("oscillator high phase wrong");

	osc_low_a: assert property ($fell(ctl_osc) |-> ##66 !ctl_osc ##1 ctl_osc)
		else $error("oscillator low phase wrong");

	cover_output_req: cover property (take && pin.dir_out);
	cover_input_req: cover property (take && !pin.dir_out ##[1:20] wr_clear);
	cover_poll_answer: cover property (irq_req_q ##[1:50] poll_match);
	cover_init_clear: cover property (init_act && cmd_q.pend);

endmodule

/* File: shared/cihp_pkg.sv */
package cihp_pkg;

	// processor instruction codes on the register selector port
	localparam int INSTR_W = 3;
	localparam logic [INSTR_W-1:0] INSTR_READ_CMD = 3'h0;
	localparam logic [INSTR_W-1:0] INSTR_READ_OUT = 3'h1;
	localparam logic [INSTR_W-1:0] INSTR_LOAD_IN = 3'h2;
	localparam logic [INSTR_W-1:0] INSTR_CLEAR_CMD = 3'h3;
	localparam logic [INSTR_W-1:0] INSTR_RAISE_IRQ = 3'h4;
	localparam logic [INSTR_W-1:0] INSTR_READ_STATUS = 3'h5;

	// data bus, select code and poll line index widths
	localparam int DATA_W = 8;
	localparam int SEL_W = 4;
	localparam int LINE_IDX_W = 3;

	// register code on the two code lines: {reg_code_hi, reg_code_lo}
	localparam logic [1:0] REG_CODE_R7 = 2'h0;
	localparam logic [1:0] REG_CODE_R6 = 2'h1;
	localparam logic [1:0] REG_CODE_R5 = 2'h2;
	localparam logic [1:0] REG_CODE_R4 = 2'h3;

	// field positions of the one-hot register select in a command read
	localparam int ONEHOT_R7_BIT = 4;
	localparam int ONEHOT_R6_BIT = 5;
	localparam int ONEHOT_R5_BIT = 6;
	localparam int ONEHOT_R4_BIT = 7;

	// field positions of the status read
	localparam int STAT_SELECTED_BIT = 0;
	localparam int STAT_POLL_BIT = 1;
	localparam int STAT_IRQ_REQ_BIT = 2;
	localparam int STAT_PENDING_BIT = 3;

	// reset values
	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	localparam logic IRQ_REQ_RESET = 1'b0;

	// control oscillator: about 2 MHz, asymmetric (one third high)
	localparam int CLK_FREQ_HZ = 200_000_000;
	localparam int OSC_FREQ_HZ = 2_000_000;
	localparam int OSC_PERIOD_CYC = CLK_FREQ_HZ / OSC_FREQ_HZ;
	localparam int OSC_HIGH_CYC = OSC_PERIOD_CYC / 3;
	localparam int OSC_CNT_W = 7;

	// calculator command latch
	typedef struct packed {
		logic pend;
		logic dir_out;
		logic code_hi;
		logic code_lo;
	} cihp_cmd_t;

	localparam cihp_cmd_t CMD_RESET = 4'h0;

	// calculator slot inputs, all asynchronous to clock
	typedef struct packed {
		logic [SEL_W-1:0] sel_code;
		logic init_n;
		logic poll_n;
		logic strobe;
		logic dir_out;
		logic code_hi;
		logic code_lo;
		logic [SEL_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cihp_pins_t;

	localparam int PINS_W = $bits(cihp_pins_t);

	// synchroniser reset: idle pin levels, so no false poll or initialize follows reset
	localparam cihp_pins_t PINS_RESET = '{sel_code: '0, init_n: 1'b1, poll_n: 1'b1, strobe: 1'b0,
		dir_out: 1'b0, code_hi: 1'b0, code_lo: 1'b0, addr: '0, data: '0};

endpackage
